/* File: can_mode_ctrl.sv */
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - bit time programmed no shorter than 40 clocks, giving 1 Mbps maximum
// - only mailbox 0 receive completion raises the transfer controller request
// - two compare matches interrupt, optionally clear counter and load offsets
// - freeze bit 11 set holds both error counters
// - freeze bit 11 clear outside configuration mode lets error counters step per protocol events
// - loopback bit 8 routes internal transmit stream into internal receive
// - loopback bit clear takes receive from the synchronised receive pin
// - reset enters configuration mode, general status bit 3 set
module can_mode_ctrl
	import can_mode_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	input  wire logic        rx_pin_in,
	input  wire logic        core_tx_in,
	input  wire logic        rx_done_in,
	input  wire logic [4:0]  rx_mailbox_in,
	input  wire logic        tx_err_inc_in,
	input  wire logic        tx_ok_in,
	input  wire logic        rx_err_inc_in,
	input  wire logic        rx_err_big_in,
	input  wire logic        rx_ok_in,
	output logic             core_rx_out,
	output logic             tx_pin_out,
	output logic             dtc_req_out,
	output logic             irq_out
);
	typedef struct packed {
		logic [15:0] master_control;
		logic [7:0]  transmit_error_counter;
		logic [7:0]  receive_error_counter;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic [15:0] timer;
		logic [15:0] cmp0;
		logic [15:0] cmp1;
		logic [15:0] offset0;
		logic [15:0] offset1;
		logic [15:0] offset_load;
		logic        rx_meta;
		logic        rx_sync;
		logic        core_rx;
		logic        tx_pin;
		logic        dtc_req;
		logic        irq;
		logic [15:0] rdata;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	function automatic logic wr_at(input logic [3:0] a);
		wr_at = wr_in && (addr_in == a);
	endfunction

	logic cfg_mode;
	logic match0;
	logic match1;
	logic [2:0] ev;
	assign cfg_mode = st_ff.master_control[MCR_CONFIG_REQ_BIT];
	assign match0 = (st_ff.timer == st_ff.cmp0) && !cfg_mode;
	assign match1 = (st_ff.timer == st_ff.cmp1) && !cfg_mode;

	always_comb begin
		nxt_st = st_ff;
		ev = IRQ_ZERO;
		nxt_st.rx_meta = rx_pin_in;
		nxt_st.rx_sync = st_ff.rx_meta;
		nxt_st.core_rx = st_ff.master_control[MCR_LOOPBACK_BIT] ? core_tx_in : st_ff.rx_sync;
		nxt_st.tx_pin = cfg_mode ? 1'b1 : core_tx_in;
		nxt_st.dtc_req = rx_done_in && (rx_mailbox_in == 5'h00) && !cfg_mode;
		ev[IRQ_RX0_BIT] = nxt_st.dtc_req;
		ev[IRQ_CMP0_BIT] = match0;
		ev[IRQ_CMP1_BIT] = match1;
		nxt_st.timer = cfg_mode ? WORD_ZERO : st_ff.timer + 16'h0001;
		if ((match0 && st_ff.master_control[MCR_CMP0_CLR_BIT]) || (match1 && st_ff.master_control[MCR_CMP1_CLR_BIT])) begin
			nxt_st.timer = WORD_ZERO;
		end
		if (match0 && st_ff.master_control[MCR_CMP0_LOAD_BIT]) begin
			nxt_st.offset_load = st_ff.offset0;
		end
		if (match1 && st_ff.master_control[MCR_CMP1_LOAD_BIT]) begin
			nxt_st.offset_load = st_ff.offset1;
		end
		if (!st_ff.master_control[MCR_FREEZE_BIT] && !cfg_mode) begin
			if (tx_err_inc_in) begin
				nxt_st.transmit_error_counter = (st_ff.transmit_error_counter > 8'hf7) ? 8'hff : st_ff.transmit_error_counter + TX_ERR_STEP;
			end else if (tx_ok_in && st_ff.transmit_error_counter != ERR_ZERO) begin
				nxt_st.transmit_error_counter = st_ff.transmit_error_counter - ERR_ONE;
			end
			if (rx_err_inc_in) begin
				if (rx_err_big_in) begin
					nxt_st.receive_error_counter = (st_ff.receive_error_counter > 8'hf7) ? 8'hff : st_ff.receive_error_counter + RX_ERR_STEP_BIG;
				end else if (st_ff.receive_error_counter != 8'hff) begin
					nxt_st.receive_error_counter = st_ff.receive_error_counter + ERR_ONE;
				end
			end else if (rx_ok_in && st_ff.receive_error_counter != ERR_ZERO) begin
				nxt_st.receive_error_counter = st_ff.receive_error_counter - ERR_ONE;
			end
		end
		if (wr_at(ADDR_MASTER_CONTROL)) begin
			nxt_st.master_control = wdata_in;
		end
		if (wr_at(ADDR_IRQ_MASK)) begin
			nxt_st.irq_mask = wdata_in[2:0];
		end
		if (wr_at(ADDR_TIMER_CMP0)) begin
			nxt_st.cmp0 = wdata_in;
		end
		if (wr_at(ADDR_TIMER_CMP1)) begin
			nxt_st.cmp1 = wdata_in;
		end
		if (wr_at(ADDR_OFFSET0)) begin
			nxt_st.offset0 = wdata_in;
		end
		if (wr_at(ADDR_OFFSET1)) begin
			nxt_st.offset1 = wdata_in;
		end
		nxt_st.irq_status = st_ff.irq_status & ~(wr_at(ADDR_IRQ_STATUS) ? wdata_in[2:0] : IRQ_ZERO);
		nxt_st.irq_status = nxt_st.irq_status | ev;
		nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
		nxt_st.rdata = WORD_ZERO;
		if (rd_in) begin
			unique case (addr_in)
				ADDR_MASTER_CONTROL: nxt_st.rdata = st_ff.master_control;
				ADDR_GENERAL_STATUS: nxt_st.rdata = {12'h000, cfg_mode, 3'h0};
				ADDR_TX_ERR:         nxt_st.rdata = {8'h00, st_ff.transmit_error_counter};
				ADDR_RX_ERR:         nxt_st.rdata = {8'h00, st_ff.receive_error_counter};
				ADDR_IRQ_STATUS:     nxt_st.rdata = {13'h0000, st_ff.irq_status};
				ADDR_IRQ_MASK:       nxt_st.rdata = {13'h0000, st_ff.irq_mask};
				ADDR_TIMER_COUNT:    nxt_st.rdata = st_ff.timer;
				ADDR_TIMER_CMP0:     nxt_st.rdata = st_ff.cmp0;
				ADDR_TIMER_CMP1:     nxt_st.rdata = st_ff.cmp1;
				ADDR_OFFSET0:        nxt_st.rdata = st_ff.offset0;
				ADDR_OFFSET1:        nxt_st.rdata = st_ff.offset1;
				ADDR_OFFSET_LOAD:    nxt_st.rdata = st_ff.offset_load;
				default:             nxt_st.rdata = WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
			st_ff.master_control <= MCR_RESET;
			st_ff.cmp0 <= 16'hffff;
			st_ff.cmp1 <= 16'hffff;
			st_ff.rx_meta <= 1'b1;
			st_ff.rx_sync <= 1'b1;
			st_ff.core_rx <= 1'b1;
			st_ff.tx_pin <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata_out   = st_ff.rdata;
	assign core_rx_out = st_ff.core_rx;
	assign tx_pin_out  = st_ff.tx_pin;
	assign dtc_req_out = st_ff.dtc_req;
	assign irq_out     = st_ff.irq;

	// bit rate bound: the protocol core must use at least this many clocks per bit
	initial begin
		if (MIN_BIT_CYCLES != 40) begin
			$error("bit rate bound wrong");
		end
	end

	AST_FREEZE_TEC: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_ff.master_control[MCR_FREEZE_BIT] && !wr_at(ADDR_MASTER_CONTROL) |=> $stable(st_ff.transmit_error_counter) && $stable(st_ff.receive_error_counter))
		else $error("error counter moved while frozen");
	AST_TEC_STEP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!st_ff.master_control[MCR_FREEZE_BIT] && !cfg_mode && tx_err_inc_in && st_ff.transmit_error_counter < 8'hf0 |=> st_ff.transmit_error_counter == $past(st_ff.transmit_error_counter) + 8'h08)
		else $error("transmit error counter did not step");
	AST_REC_DEC: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!st_ff.master_control[MCR_FREEZE_BIT] && !cfg_mode && !rx_err_inc_in && rx_ok_in && st_ff.receive_error_counter != 8'h00
		|=> st_ff.receive_error_counter == $past(st_ff.receive_error_counter) - 8'h01)
		else $error("receive error counter did not decrement");
	AST_LOOP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_ff.master_control[MCR_LOOPBACK_BIT] |=> core_rx_out == $past(core_tx_in))
		else $error("loopback path wrong");
	AST_PIN_RX: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!st_ff.master_control[MCR_LOOPBACK_BIT] ##1 !st_ff.master_control[MCR_LOOPBACK_BIT] ##1 !st_ff.master_control[MCR_LOOPBACK_BIT]
		|=> core_rx_out == $past(rx_pin_in, 3))
		else $error("receive not from pin");
	AST_DTC_MB0: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		dtc_req_out |-> $past(rx_done_in) && $past(rx_mailbox_in) == 5'h00)
		else $error("transfer request from wrong mailbox");
	AST_CMP_CLR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		match0 && st_ff.master_control[MCR_CMP0_CLR_BIT] |=> st_ff.timer == 16'h0000 && st_ff.irq_status[IRQ_CMP0_BIT])
		else $error("compare match did not clear timer");
	AST_CFG_STATUS: assert property (@(posedge sys_clk_in)
		!rst_n_in |=> rst_n_in |-> cfg_mode && tx_pin_out)
		else $error("reset did not enter configuration mode");
	AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		irq_out == |(st_ff.irq_status & st_ff.irq_mask))
		else $error("interrupt level mismatch");
	COV_LOOP: cover property (@(posedge sys_clk_in) st_ff.master_control[MCR_LOOPBACK_BIT] && core_tx_in);
	COV_DTC: cover property (@(posedge sys_clk_in) dtc_req_out);
	COV_CMP1: cover property (@(posedge sys_clk_in) match1 && st_ff.master_control[MCR_CMP1_LOAD_BIT]);
	COV_FREEZE: cover property (@(posedge sys_clk_in) st_ff.master_control[MCR_FREEZE_BIT] && tx_err_inc_in);
endmodule // can_mode_ctrl

/* File: can_mode_pkg.sv */
package can_mode_pkg;
	localparam logic [3:0]  ADDR_MASTER_CONTROL = 4'h0;
	localparam logic [3:0]  ADDR_GENERAL_STATUS = 4'h1;
	localparam logic [3:0]  ADDR_TX_ERR         = 4'h2;
	localparam logic [3:0]  ADDR_RX_ERR         = 4'h3;
	localparam logic [3:0]  ADDR_IRQ_STATUS     = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_MASK       = 4'h5;
	localparam logic [3:0]  ADDR_TIMER_COUNT    = 4'h6;
	localparam logic [3:0]  ADDR_TIMER_CMP0     = 4'h7;
	localparam logic [3:0]  ADDR_TIMER_CMP1     = 4'h8;
	localparam logic [3:0]  ADDR_OFFSET0        = 4'h9;
	localparam logic [3:0]  ADDR_OFFSET1        = 4'ha;
	localparam logic [3:0]  ADDR_OFFSET_LOAD    = 4'hb;
	localparam int          MCR_CONFIG_REQ_BIT  = 0;
	localparam int          MCR_LOOPBACK_BIT    = 8;
	localparam int          MCR_FREEZE_BIT      = 11;
	localparam int          MCR_CMP0_CLR_BIT    = 12;
	localparam int          MCR_CMP1_CLR_BIT    = 13;
	localparam int          MCR_CMP0_LOAD_BIT   = 14;
	localparam int          MCR_CMP1_LOAD_BIT   = 15;
	localparam int          GSR_CONFIG_BIT      = 3;
	localparam logic [15:0] MCR_RESET           = 16'h0001;
	localparam logic [15:0] WORD_ZERO           = 16'h0000;
	localparam logic [7:0]  ERR_ZERO            = 8'h00;
	localparam int          IRQ_RX0_BIT         = 0;
	localparam int          IRQ_CMP0_BIT        = 1;
	localparam int          IRQ_CMP1_BIT        = 2;
	localparam logic [2:0]  IRQ_ZERO            = 3'h0;
	localparam int          CLK_HZ              = 40000000;
	localparam int          MAX_BIT_RATE_BPS    = 1000000;
	localparam int          MIN_BIT_CYCLES      = CLK_HZ / MAX_BIT_RATE_BPS;
	localparam logic [7:0]  TX_ERR_STEP         = 8'h08;
	localparam logic [7:0]  RX_ERR_STEP_BIG     = 8'h08;
	localparam logic [7:0]  ERR_ONE             = 8'h01;
endpackage

/* File: can_bus_model.sv */
`timescale 1ns/1ps
module can_bus_model (
	input  wire logic tx_pin_in,
	input  wire logic node_dom_in,
	output logic      rx_pin_out
);
	// wired-and bus: another node sending dominant pulls the line low
	assign rx_pin_out = tx_pin_in & ~node_dom_in;
endmodule // can_bus_model

/* File: can_mode_ctrl_tb.sv */
`timescale 1ns/1ps
module can_mode_ctrl_tb;
	import can_mode_pkg::*;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ctx = 1, dom = 0, rxd = 0;
	logic [3:0]  adr = 4'h0;
	logic [15:0] wd = 16'h0000, rdv, rdat;
	logic [4:0]  ev = 5'h00, mb = 5'h00;
	logic        rxp, crx, txp, dreq, irq;
	int          err_count = 0, num_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	can_mode_ctrl i_can_mode_ctrl (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(adr), .wdata_in(wd),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdat), .rx_pin_in(rxp), .core_tx_in(ctx), .rx_done_in(rxd),
		.rx_mailbox_in(mb), .tx_err_inc_in(ev[0]), .tx_ok_in(ev[1]), .rx_err_inc_in(ev[2]),
		.rx_err_big_in(ev[3]), .rx_ok_in(ev[4]), .core_rx_out(crx), .tx_pin_out(txp),
		.dtc_req_out(dreq), .irq_out(irq));
	can_bus_model i_can_bus_model (.tx_pin_in(txp), .node_dom_in(dom), .rx_pin_out(rxp));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string m);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		rdv = rdat;
		chk(rdv, e, m);
	endtask
	task automatic pulse(input logic [4:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 5'h00;
	endtask
	task automatic rxdone(input logic [4:0] m, input logic e);
		@(posedge clk);
		rxd <= 1'b1;
		mb <= m;
		@(posedge clk);
		rxd <= 1'b0;
		#1;
		chk({15'h0000, dreq}, {15'h0000, e}, "dtc");
	endtask
	task automatic pin_chk(input int n, ref logic p, input logic e, input string m);
		repeat (n) @(posedge clk);
		#1;
		chk({15'h0000, p}, {15'h0000, e}, m);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		ctx <= 1'b0;
		rd_chk(ADDR_GENERAL_STATUS, 16'h0008, "gsr");
		rd_chk(ADDR_MASTER_CONTROL, MCR_RESET, "mcr");
		pin_chk(1, txp, 1'b1, "txpin cfg");
		rd_chk(4'hf, WORD_ZERO, "unmapped");
		wr_reg(ADDR_IRQ_MASK, 16'h0007);
		wr_reg(ADDR_MASTER_CONTROL, WORD_ZERO);
		pin_chk(4, txp, 1'b0, "txpin run");
		$display("test reset done");
		pulse(5'h01);
		pulse(5'h01);
		pulse(5'h02);
		rd_chk(ADDR_TX_ERR, 16'h000f, "tec");
		pulse(5'h0c);
		pulse(5'h04);
		pulse(5'h10);
		rd_chk(ADDR_RX_ERR, 16'h0008, "rec");
		wr_reg(ADDR_MASTER_CONTROL, 16'h0800);
		pulse(5'h05);
		pulse(5'h12);
		rd_chk(ADDR_TX_ERR, 16'h000f, "tec frz");
		rd_chk(ADDR_RX_ERR, 16'h0008, "rec frz");
		$display("test counters done");
		rxdone(5'h05, 1'b0);
		rd_chk(ADDR_IRQ_STATUS, WORD_ZERO, "no rx0");
		rxdone(5'h00, 1'b1);
		chk({15'h0000, irq}, 16'h0001, "irq");
		rd_chk(ADDR_IRQ_STATUS, 16'h0001, "rx0");
		wr_reg(ADDR_IRQ_MASK, WORD_ZERO);
		pin_chk(2, irq, 1'b0, "irq masked");
		wr_reg(ADDR_IRQ_MASK, 16'h0007);
		pin_chk(2, irq, 1'b1, "irq unmasked");
		wr_reg(ADDR_IRQ_STATUS, 16'h0001);
		pin_chk(2, irq, 1'b0, "irq clr");
		rd_chk(ADDR_IRQ_STATUS, WORD_ZERO, "w1c");
		$display("test events done");
		wr_reg(ADDR_MASTER_CONTROL, 16'h0100);
		@(posedge clk);
		dom <= 1'b1;
		ctx <= 1'b1;
		pin_chk(3, crx, 1'b1, "loop hi");
		@(posedge clk);
		ctx <= 1'b0;
		pin_chk(3, crx, 1'b0, "loop lo");
		wr_reg(ADDR_MASTER_CONTROL, WORD_ZERO);
		@(posedge clk);
		ctx <= 1'b1;
		pin_chk(6, crx, 1'b0, "pin dom");
		@(posedge clk);
		dom <= 1'b0;
		pin_chk(6, crx, 1'b1, "pin rec");
		$display("test loopback done");
		wr_reg(ADDR_MASTER_CONTROL, MCR_RESET);
		rd_chk(ADDR_TIMER_COUNT, WORD_ZERO, "tcnt");
		wr_reg(ADDR_TIMER_CMP0, 16'h0010);
		wr_reg(ADDR_OFFSET0, 16'h1234);
		wr_reg(ADDR_MASTER_CONTROL, 16'h5000);
		pin_chk(40, irq, 1'b1, "cmp irq");
		rd_chk(ADDR_IRQ_STATUS, 16'h0002, "cmp0");
		rd_chk(ADDR_OFFSET_LOAD, 16'h1234, "offload");
		$display("test timer done");
		test_done();
	end
endmodule // can_mode_ctrl_tb
